// ===== rtl/bcc_charger_ctrl.sv
// Purpose: register file and charge sequencer of a li-ion switching charger
// Assumes: analog comparators arrive asynchronously and are synchronised here
// Notes: apb slave, zero wait states, unmapped reads give zero
//
// Summary of operation
// RL1 - three modes exist: charge, boost, and high impedance with paths off.
// RL2 - below the short-circuit threshold precharge linearly, then pwm.
// RL3 - current termination acts only when the termination enable bit is set.
// RL4 - float code 0-35 gives 4.20, 36-40 4.30, 41-43 4.35, 44-62 4.40 V.
// RL5 - charge current code 0..7 selects 37.5 to 101.8 mV sense threshold.
// RL6 - input limit code 00 100 mA, 01 500 mA, 10 800 mA, 11 no limit.
// RL7 - termination code 0..7 selects 3.1 to 25 mV sense threshold.
// RL8 - recharge offset code 0..3 selects 50, 100, 150 or 200 mV.
// RL9 - a new cycle starts when the battery falls below float minus offset.
// RL10 - a new cycle starts when supply reset clears with battery shorted.
// RL11 - clearing charge-disable or high-impedance by a write starts a cycle.
// RL12 - on termination report ready for 30 ms, then done if still connected.
// RL13 - above the supply minimum apply a load; charge after 30 ms valid.
// RL14 - supply validation runs on every start and restart of charging.
// RL15 - the host programs voltage, currents and termination by register.
// RL16 - charge-disable or high-impedance set forces high-impedance mode; with charge-disable alone boost_on still follows the boost bit.
// RL17 - leaving the valid window restarts the full validation count.
`timescale 1ns/10ps
`include "bcc_map.svh"
module bcc_charger_ctrl #(
  parameter int VALID_CYCLES = `BCC_VALID_MS * 1000 * `BCC_CLK_MHZ,
  parameter int DONE_CYCLES = `BCC_DONE_MS * 1000 * `BCC_CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_above_min,
  input wire logic supply_overvoltage,
  input wire logic battery_below_short,
  input wire logic battery_below_recharge,
  input wire logic current_below_term,
  input wire logic battery_connected,
  output logic supply_load_on,
  output logic precharge_on,
  output logic pwm_charge_on,
  output logic boost_on,
  output logic [1:0] float_voltage_sel,
  output logic [2:0] charge_current_limit,
  output logic [1:0] input_current_limit,
  output logic [2:0] termination_current_code,
  output logic [1:0] recharge_offset
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for the analog comparators
  localparam int NS = 6;
  logic [NS-1:0] async_in;
  logic [NS-1:0] sync_out;
  assign async_in = {supply_above_min, supply_overvoltage,
                     battery_below_short, battery_below_recharge,
                     current_below_term, battery_connected};
  // one two-stage chain per comparator; only stage two feeds logic
  for (genvar g = 0; g < NS; g++) begin : g_sync
    logic s1_reg;
    logic s2_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
      end else begin
        s1_reg <= async_in[g];
        s2_reg <= s1_reg;
      end
    end
    assign sync_out[g] = s2_reg;
  end
  logic sup_ok;
  logic bat_short;
  logic bat_rech;
  logic cur_low;
  logic bat_conn;
  logic sup_min;
  assign sup_min = sync_out[5];
  assign sup_ok = sync_out[5] & ~sync_out[4];
  assign bat_short = sync_out[3];
  assign bat_rech = sync_out[2];
  assign cur_low = sync_out[1];
  assign bat_conn = sync_out[0];

  ////////////////////////////////////////////////////////////////////////////
  // apb register file
  logic [7:0] ctrl1_reg;
  logic [7:0] float_reg;
  logic [7:0] curr_reg;
  logic [7:0] rech_reg;
  logic [1:0] stat_reg;
  logic [2:0] idx;
  logic mapped;
  logic wr_en;
  assign idx = paddr[4:2];
  // upper address bits must be zero, so aliases never reach a register
  assign mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0) &&
                  (idx == `BCC_IDX_STAT || idx == `BCC_IDX_CTRL1 ||
                   idx == `BCC_IDX_FLOAT || idx == `BCC_IDX_CURR ||
                   idx == `BCC_IDX_RECH);
  assign wr_en = psel & penable & pwrite & mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_reg <= `BCC_RST_CTRL1;
      float_reg <= `BCC_RST_FLOAT;
      curr_reg <= `BCC_RST_CURR;
      rech_reg <= `BCC_RST_RECH;
    end else if (wr_en) begin
      // host programs every charging parameter here
      case (idx) // RL15
        `BCC_IDX_CTRL1: ctrl1_reg <= pwdata[7:0];
        `BCC_IDX_FLOAT: float_reg <= {pwdata[7:2], 2'h0};
        `BCC_IDX_CURR: curr_reg <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
        `BCC_IDX_RECH: rech_reg <= {6'h00, pwdata[1:0]};
        default: ;
      endcase
    end
  end

  // zero wait states; unmapped answers with pslverr and zero data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite && mapped) begin
        case (idx)
          `BCC_IDX_STAT: prdata <= {24'h000000, 2'h0, stat_reg, 4'h0};
          `BCC_IDX_CTRL1: prdata <= {24'h000000, ctrl1_reg};
          `BCC_IDX_FLOAT: prdata <= {24'h000000, float_reg};
          `BCC_IDX_CURR: prdata <= {24'h000000, curr_reg};
          `BCC_IDX_RECH: prdata <= {24'h000000, rech_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  logic [5:0] fcode;
  logic disable_req;
  logic restart_wr;
  assign fcode = float_reg[7:2];
  assign disable_req = ctrl1_reg[`BCC_CE_BIT] | ctrl1_reg[`BCC_HZ_BIT];
  // a write that clears a set disable bit and leaves both disable bits clear restarts charging
  assign restart_wr = wr_en && idx == `BCC_IDX_CTRL1 && // RL11
    ((ctrl1_reg[`BCC_CE_BIT] && !pwdata[`BCC_CE_BIT]) ||
     (ctrl1_reg[`BCC_HZ_BIT] && !pwdata[`BCC_HZ_BIT])) &&
    !pwdata[`BCC_CE_BIT] && !pwdata[`BCC_HZ_BIT];

  // codes past the last band still give the top target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      float_voltage_sel <= 2'h0;
    end else begin
      if (fcode <= 6'h23) float_voltage_sel <= 2'h0; // RL4
      else if (fcode <= 6'h28) float_voltage_sel <= 2'h1;
      else if (fcode <= 6'h2B) float_voltage_sel <= 2'h2;
      else float_voltage_sel <= 2'h3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_current_limit <= 3'h0;
      input_current_limit <= 2'h0;
      termination_current_code <= 3'h0;
      recharge_offset <= 2'h0;
    end else begin
      charge_current_limit <= curr_reg[6:4]; // RL5
      input_current_limit <= ctrl1_reg[7:6]; // RL6
      termination_current_code <= curr_reg[2:0]; // RL7
      recharge_offset <= rech_reg[1:0]; // RL8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge sequencer
  bcc_pkg::bcc_state_t state_reg;
  // one timer serves both the validation and the done windows
  logic [31:0] tmr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= bcc_pkg::BCC_IDLE;
      tmr_reg <= 32'h0000_0000;
    end else if (restart_wr) begin
      // the clearing write wins over the disable bits it replaces
      state_reg <= bcc_pkg::BCC_VALIDATE; // RL11 RL14
      tmr_reg <= 32'h0000_0000;
    end else if (disable_req) begin
      state_reg <= bcc_pkg::BCC_HIZ; // RL16
      tmr_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        bcc_pkg::BCC_HIZ: begin
          // stays off until a clearing write restarts charging
          tmr_reg <= 32'h0000_0000;
        end
        bcc_pkg::BCC_IDLE: begin
          tmr_reg <= 32'h0000_0000;
          if (sup_min) state_reg <= bcc_pkg::BCC_VALIDATE; // RL14
        end
        bcc_pkg::BCC_VALIDATE: begin
          if (!sup_ok) begin
            // a glitch costs a full window; no partial credit is kept
            tmr_reg <= 32'h0000_0000; // RL17
            if (!sup_min) state_reg <= bcc_pkg::BCC_IDLE;
          end else if (tmr_reg >= 32'(VALID_CYCLES - 1)) begin // RL13
            tmr_reg <= 32'h0000_0000;
            state_reg <= bat_short ? bcc_pkg::BCC_PRECHARGE // RL10
                                   : bcc_pkg::BCC_FASTCHG;
          end else begin
            tmr_reg <= tmr_reg + 32'h1;
          end
        end
        bcc_pkg::BCC_PRECHARGE: begin
          if (!sup_ok) state_reg <= bcc_pkg::BCC_VALIDATE; // RL14
          else if (!bat_short) state_reg <= bcc_pkg::BCC_FASTCHG; // RL2
        end
        bcc_pkg::BCC_FASTCHG: begin
          tmr_reg <= 32'h0000_0000;
          if (!sup_ok) state_reg <= bcc_pkg::BCC_VALIDATE; // RL14
          else if (bat_short) state_reg <= bcc_pkg::BCC_PRECHARGE; // RL2
          else if (cur_low && ctrl1_reg[`BCC_TE_BIT])
            state_reg <= bcc_pkg::BCC_DONECHK; // RL3
        end
        bcc_pkg::BCC_DONECHK: begin
          if (tmr_reg >= 32'(DONE_CYCLES - 1)) begin // RL12
            tmr_reg <= 32'h0000_0000;
            state_reg <= (bat_conn && sup_ok) ? bcc_pkg::BCC_DONE
                                              : bcc_pkg::BCC_IDLE;
          end else begin
            tmr_reg <= tmr_reg + 32'h1;
          end
        end
        bcc_pkg::BCC_DONE: begin
          tmr_reg <= 32'h0000_0000;
          if (!sup_ok) state_reg <= bcc_pkg::BCC_IDLE;
          else if (bat_rech) state_reg <= bcc_pkg::BCC_VALIDATE; // RL9 RL14
        end
        default: begin
          state_reg <= bcc_pkg::BCC_IDLE;
          tmr_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode outputs and status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_load_on <= 1'b0;
      precharge_on <= 1'b0;
      pwm_charge_on <= 1'b0;
    end else begin
      // load only while the supply is being qualified
      supply_load_on <= state_reg == bcc_pkg::BCC_VALIDATE && sup_min; // RL13
      precharge_on <= state_reg == bcc_pkg::BCC_PRECHARGE; // RL2
      pwm_charge_on <= state_reg == bcc_pkg::BCC_FASTCHG; // RL2
    end
  end

  // boost only while the high-impedance bit is clear; both charge paths off in high impedance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_on <= 1'b0;
    end else begin
      boost_on <= ctrl1_reg[`BCC_BOOST_BIT] && // RL1
                  !ctrl1_reg[`BCC_HZ_BIT] &&
                  state_reg != bcc_pkg::BCC_PRECHARGE &&
                  state_reg != bcc_pkg::BCC_FASTCHG;
    end
  end

  // status lags the state by one clock, as the mode outputs do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= `BCC_ST_READY;
    end else begin
      case (state_reg)
        bcc_pkg::BCC_PRECHARGE, bcc_pkg::BCC_FASTCHG:
          stat_reg <= `BCC_ST_CHARGING;
        bcc_pkg::BCC_DONE: stat_reg <= `BCC_ST_DONE; // RL12
        default: stat_reg <= `BCC_ST_READY;
      endcase
    end
  end

endmodule

// ===== rtl/bcc_map.svh
// Purpose: offsets, fields, reset values and timing of the charger control
// Assumes: 32-bit apb words, byte addresses = 4 * register index
// Notes: definitions only
`ifndef BCC_MAP_SVH
`define BCC_MAP_SVH
`define BCC_IDX_CTRL1 3'h1
`define BCC_IDX_FLOAT 3'h2
`define BCC_IDX_CURR 3'h4
`define BCC_IDX_RECH 3'h7
`define BCC_IDX_STAT 3'h0
`define BCC_RST_CTRL1 8'h40
`define BCC_RST_FLOAT 8'h00
`define BCC_RST_CURR 8'h00
`define BCC_RST_RECH 8'h00
`define BCC_CE_BIT 2
`define BCC_HZ_BIT 1
`define BCC_BOOST_BIT 0
`define BCC_TE_BIT 3
`define BCC_CLK_MHZ 125
`define BCC_VALID_MS 30
`define BCC_DONE_MS 30
`define BCC_ST_READY 2'h0
`define BCC_ST_CHARGING 2'h1
`define BCC_ST_DONE 2'h2
`define BCC_ST_FAULT 2'h3
`endif

// ===== rtl/bcc_pkg.sv
// Purpose: types of the charger control
// Assumes: nothing
// Notes: gray-coded charge sequence
package bcc_pkg;
  typedef enum logic [2:0] {
    BCC_IDLE = 3'h0,
    BCC_VALIDATE = 3'h1,
    BCC_PRECHARGE = 3'h3,
    BCC_FASTCHG = 3'h2,
    BCC_DONECHK = 3'h6,
    BCC_DONE = 3'h7,
    BCC_HIZ = 3'h5
  } bcc_state_t;
endpackage

// ===== tb/bcc_charger_ctrl_asserts.sv
// Purpose: port checks of the charger control
// Assumes: zero wait apb slave, field copies two edges after the write
// Notes: bound at the foot
`timescale 1ns/10ps
module bcc_charger_ctrl_asserts #(
  parameter int VALID_CYCLES = 20
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic pslverr,
  input logic supply_above_min,
  input logic supply_overvoltage,
  input logic supply_load_on,
  input logic precharge_on,
  input logic pwm_charge_on,
  input logic boost_on,
  input logic [1:0] float_voltage_sel,
  input logic [2:0] charge_current_limit,
  input logic [1:0] input_current_limit,
  input logic [2:0] termination_current_code,
  input logic [1:0] recharge_offset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int vcnt;
  ////////////////////////////////////////////////////////////////////////
  // raw window length; the dut sees it two cycles late, so never longer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      vcnt <= 0;
    else
      vcnt <= (supply_above_min && !supply_overvoltage) ? vcnt + 1 : 0;
  end
  function automatic logic [1:0] fmap(input logic [5:0] c);
    return c < 6'h24 ? 2'h0 : c < 6'h29 ? 2'h1 : c < 6'h2C ? 2'h2 : 2'h3;
  endfunction
  sequence s_wr(logic [7:0] a); psel && penable && pwrite && paddr == a; endsequence
  sequence s_start; $rose(precharge_on) || $rose(pwm_charge_on) &&
    !$past(precharge_on); endsequence
  ////////////////////////////////////////////////////////////////////////
  property p_ready; psel && !penable |=> pready && penable; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_refuse; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr; endproperty
  a_refuse: assert property (p_refuse) else $error("misaligned accepted");
  property p_excl; !(pwm_charge_on && precharge_on) &&
    !(boost_on && (pwm_charge_on || precharge_on)); endproperty
  a_excl: assert property (p_excl) else $error("modes overlap");
  property p_hiz; s_wr(8'h04) ##0 pwdata[2:1] != 2'h0 && !pwdata[0] |->
    ##3 !(pwm_charge_on || precharge_on || boost_on); endproperty
  a_hiz: assert property (p_hiz) else $error("paths on after disable");
  property p_valid; s_start |-> $past(supply_load_on) &&
    vcnt >= VALID_CYCLES; endproperty
  a_valid: assert property (p_valid) else $error("charge before valid");
  property p_float; s_wr(8'h08) ##2 1 |->
    float_voltage_sel == fmap($past(pwdata[7:2], 2)); endproperty
  a_float: assert property (p_float) else $error("float select wrong");
  property p_curr; s_wr(8'h10) ##2 1 |-> charge_current_limit ==
    $past(pwdata[6:4], 2) && termination_current_code ==
    $past(pwdata[2:0], 2); endproperty
  a_curr: assert property (p_curr) else $error("current codes wrong");
  property p_ilim; s_wr(8'h04) ##2 1 |->
    input_current_limit == $past(pwdata[7:6], 2); endproperty
  a_ilim: assert property (p_ilim) else $error("input limit wrong");
  property p_rech; s_wr(8'h1C) ##2 1 |->
    recharge_offset == $past(pwdata[1:0], 2); endproperty
  a_rech: assert property (p_rech) else $error("recharge offset wrong");
endmodule
bind bcc_charger_ctrl bcc_charger_ctrl_asserts #(
  .VALID_CYCLES(VALID_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .supply_above_min(supply_above_min),
  .supply_overvoltage(supply_overvoltage),
  .supply_load_on(supply_load_on), .precharge_on(precharge_on),
  .pwm_charge_on(pwm_charge_on), .boost_on(boost_on),
  .float_voltage_sel(float_voltage_sel),
  .charge_current_limit(charge_current_limit),
  .input_current_limit(input_current_limit),
  .termination_current_code(termination_current_code),
  .recharge_offset(recharge_offset));

// ===== tb/bcc_charger_ctrl_tb.sv
// Purpose: self-checking bench of the charger control
// Assumes: short validation and done counts
// Notes: register model indexed by word
`timescale 1ns/10ps
module bcc_charger_ctrl_tb;
  localparam int VC = 20;
  localparam int DC = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, supply_en = 0, ovp = 0, drain = 0;
  logic supply_above_min, supply_overvoltage, battery_below_short;
  logic battery_below_recharge, current_below_term, battery_connected;
  logic supply_load_on, precharge_on, pwm_charge_on, boost_on;
  logic [1:0] float_voltage_sel, input_current_limit, recharge_offset;
  logic [2:0] charge_current_limit, termination_current_code, so;
  int err_count = 0, n_compared = 0, n, v;
  int mdl [8] = '{0, 64, 0, 0, 0, 0, 0, 0};
  assign so = {supply_load_on, precharge_on, pwm_charge_on};
  always #4 pclk = ~pclk;
  bcc_charger_ctrl #(.VALID_CYCLES(VC), .DONE_CYCLES(DC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .supply_above_min(supply_above_min),
    .supply_overvoltage(supply_overvoltage),
    .battery_below_short(battery_below_short),
    .battery_below_recharge(battery_below_recharge),
    .current_below_term(current_below_term),
    .battery_connected(battery_connected),
    .supply_load_on(supply_load_on), .precharge_on(precharge_on),
    .pwm_charge_on(pwm_charge_on), .boost_on(boost_on),
    .float_voltage_sel(float_voltage_sel),
    .charge_current_limit(charge_current_limit),
    .input_current_limit(input_current_limit),
    .termination_current_code(termination_current_code),
    .recharge_offset(recharge_offset));
  bcc_plant u_plant (
    .pclk(pclk), .supply_en(supply_en), .ovp(ovp), .drain(drain),
    .precharge_on(precharge_on), .pwm_charge_on(pwm_charge_on),
    .supply_above_min(supply_above_min),
    .supply_overvoltage(supply_overvoltage),
    .battery_below_short(battery_below_short),
    .battery_below_recharge(battery_below_recharge),
    .current_below_term(current_below_term),
    .battery_connected(battery_connected));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 20) begin
      err_count++;
      final_report();
    end
    if (!w)
      check(prdata, x);
    check(32'(pslverr), 32'(!(a inside {8'h00, 8'h04, 8'h08, 8'h10,
      8'h1C})));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait on one sequencer output, leaves the cycle count in n
  task automatic wait_on(input int s, input logic lv);
    n = 0;
    while (so[s] !== lv && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      err_count++;
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(12);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
      bus(0, 8'(i * 4), 0, mdl[i]);
    bus(1, 8'h0C, 32'hFF, 0);
    bus(0, 8'h05, 0, 0);
    $display("reset and map test done");
    for (int i = 0; i < 63; i++) begin
      v = $urandom;
      mdl[2] = i << 2;
      mdl[4] = v & 32'h77;
      mdl[7] = v & 3;
      bus(1, 8'h08, mdl[2], 0);
      bus(1, 8'h10, mdl[4], 0);
      bus(1, 8'h1C, mdl[7], 0);
      bus(1, 8'h04, ((i & 3) << 6) | (i & 1), 0);
      bus(0, 8'h08, 0, mdl[2]);
      repeat (2) @(posedge pclk);
      check(32'(float_voltage_sel), i < 36 ? 0 : i < 41 ? 1 : i < 44 ? 2 : 3);
      check(32'({charge_current_limit, termination_current_code}), mdl[4] >> 4 << 3 | mdl[4] & 7);
      check(32'(recharge_offset), mdl[7]);
      check(32'(input_current_limit), i & 3);
      check(32'(boost_on), i & 1);
    end
    $display("field test done");
    bus(1, 8'h04, 32'h40, 0);
    supply_en <= 1'b1;
    repeat (VC / 2) @(posedge pclk);
    ovp <= 1'b1;
    @(posedge pclk);
    ovp <= 1'b0;
    wait_on(1, 1'b1);
    check(32'(n >= VC), 1);
    wait_on(0, 1'b1);
    check(32'(precharge_on), 0);
    bus(0, 8'h00, 0, 32'h10);
    repeat (60) @(posedge pclk);
    check(32'(pwm_charge_on), 1);
    bus(1, 8'h04, 32'h44, 0);
    repeat (4) @(posedge pclk);
    check(32'({so, boost_on}), 0);
    bus(1, 8'h04, 32'h48, 0);
    wait_on(2, 1'b1);
    wait_on(0, 1'b1);
    wait_on(0, 1'b0);
    bus(0, 8'h00, 0, 32'h00);
    repeat (DC + 6) @(posedge pclk);
    bus(0, 8'h00, 0, 32'h20);
    drain <= 1'b1;
    @(posedge pclk);
    drain <= 1'b0;
    wait_on(2, 1'b1);
    wait_on(0, 1'b1);
    bus(1, 8'h04, 32'h4B, 0);
    repeat (4) @(posedge pclk);
    check(32'({so, boost_on}), 0);
    $display("charge sequence test done");
    final_report();
  end
endmodule

// ===== tb/bcc_plant.sv
// Purpose: supply and cell seen by the charger control
// Assumes: cell level climbs one step per clock while a charge path is on
// Notes: levels 8, 24 and 30 stand for the analog thresholds
`timescale 1ns/10ps
module bcc_plant (
  input logic pclk,
  input logic supply_en,
  input logic ovp,
  input logic drain,
  input logic precharge_on,
  input logic pwm_charge_on,
  output logic supply_above_min,
  output logic supply_overvoltage,
  output logic battery_below_short,
  output logic battery_below_recharge,
  output logic current_below_term,
  output logic battery_connected
);
  int lvl = 0;
  always @(posedge pclk) begin
    if (drain)
      lvl <= 20;
    else if ((precharge_on || pwm_charge_on) && lvl < 40)
      lvl <= lvl + 1;
  end
  assign supply_above_min = supply_en;
  assign supply_overvoltage = ovp;
  assign battery_below_short = lvl < 8;
  assign battery_below_recharge = lvl < 24;
  // a full cell takes little current, so the tail shows here
  assign current_below_term = lvl >= 30;
  assign battery_connected = 1'b1;
endmodule
